// *** src/pswc_defines.svh ***
`ifndef PSWC_DEFINES_SVH
`define PSWC_DEFINES_SVH

// Register byte offsets
`define PSWC_CTRL_OFF      12'h000
`define PSWC_STATUS_OFF    12'h004
`define PSWC_WAKE_EN_OFF   12'h008
`define PSWC_CAUSE_OFF     12'h00C
`define PSWC_TIMER_OFF     12'h010
`define PSWC_GPIO_CFG_OFF  12'h014
`define PSWC_CRIT_OFF      12'h018
`define PSWC_CRIT_CHK_OFF  12'h01C

// Control register fields
`define PSWC_CTRL_SLEEP    0
`define PSWC_CTRL_DOZE     1
`define PSWC_CTRL_SWRST    2

// Cause register fields
`define PSWC_CAUSE_POR     0
`define PSWC_CAUSE_EXTRST  1
`define PSWC_CAUSE_SWRST   2
`define PSWC_CAUSE_BROWN   3
`define PSWC_CAUSE_CRIT    4
`define PSWC_CAUSE_FORCE   5
`define PSWC_CAUSE_TIMER   6
`define PSWC_CAUSE_SRC     7
`define PSWC_CAUSE_GPIO    8
`define PSWC_CAUSE_W       9

// Wake source count: timer, sensor, tag, magnetic, loop
`define PSWC_NSRC          5
`define PSWC_NGPIO         4

// Reset values
`define PSWC_WAKE_EN_RST   5'h1F
`define PSWC_CRIT_RST      16'h0000

// Timing: clock 200 MHz
`define PSWC_CLK_MHZ       200
`define PSWC_FORCE_US      245
`define PSWC_FORCE_CYC     (`PSWC_FORCE_US * `PSWC_CLK_MHZ)
`define PSWC_DOZE_NS       45
`define PSWC_DOZE_CYC      ((`PSWC_DOZE_NS * `PSWC_CLK_MHZ) / 1000)
`define PSWC_RST_HOLD      8'h10
`define PSWC_PWR_SETTLE    8'h20

`endif

// *** src/pswc_pkg.sv ***
package pswc_pkg;

   typedef enum logic [2:0] {
      PSWC_ST_RESET   = 3'b000,
      PSWC_ST_RESTORE = 3'b001,
      PSWC_ST_POWERUP = 3'b010,
      PSWC_ST_AWAKE   = 3'b011,
      PSWC_ST_DOZE    = 3'b100,
      PSWC_ST_ASLEEP  = 3'b101
   } pswc_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pswc_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } pswc_apb_rsp_t;

   typedef struct packed {
      logic core_pwr_en;
      logic io_pwr_en;
      logic osc_en;
      logic cpu_clk_en;
      logic core_rst_n;
   } pswc_pwr_t;

   typedef struct packed {
      logic req;
      logic done;
   } pswc_restore_t;

endpackage : pswc_pkg

// *** src/pswc_power_manager.sv ***
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "pswc_defines.svh"

module pswc_power_manager (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire pswc_pkg::pswc_apb_req_t apb_req,
   output pswc_pkg::pswc_apb_rsp_t    apb_rsp,
   // Reset sources
   input  wire logic                  por_n,
   input  wire logic                  ext_reset_n,
   input  wire logic                  brownout,
   // Wake and interrupt sources
   input  wire logic                  hold_awake,
   input  wire logic [4:0]            wake_src,
   input  wire logic [3:0]            gpio_in,
   // Always-on memory restore handshake
   input  wire logic                  restore_done,
   output pswc_pkg::pswc_restore_t    restore,
   // Power and clock controls
   output pswc_pkg::pswc_pwr_t        pwr,
   output logic                       cpu_irq
);
   import pswc_pkg::*;

   localparam int FORCE_CYC = `PSWC_FORCE_CYC;

   pswc_state_t state_reg;
   logic [31:0] force_cnt_reg;
   logic        force_evt_reg;
   logic        force_seen_reg;
   logic [4:0]  wake_en_reg;
   logic [9:0]  cause_reg;
   logic [31:0] timer_reg;
   logic        timer_run_reg;
   logic [7:0]  gpio_cfg_reg;
   logic [3:0]  gpio_prev_reg;
   logic [3:0]  gpio_pend_reg;
   logic [15:0] crit_reg;
   logic [15:0] crit_chk_reg;
   logic [7:0]  seq_cnt_reg;
   logic        brown_seen_reg;
   logic        swrst_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        restore_req_reg;

   logic        wr_en;
   logic        rd_en;
   logic        wake_any;
   logic        crit_fail;
   logic        rst_src;
   logic        timer_exp;
   logic [4:0]  src_hit;
   logic [3:0]  gpio_hit;
   logic [9:0]  cause_set;

   // Address decode helper
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction : hit

   // APB strobes, accepted in the access phase
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_reg;
   assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;

   // Critical register consistency: copy must be bitwise inverse
   assign crit_fail = (crit_reg != ~crit_chk_reg);

   // Any reset source
   assign rst_src = ~por_n | ~ext_reset_n | swrst_reg | brownout
                    | crit_fail;

   // Timer expiry
   assign timer_exp = timer_run_reg & (timer_reg == 32'h0000_0001);

   // Wake sources gated by software enables; timer joins as source 0
   always_comb begin
      src_hit    = wake_src & wake_en_reg;
      src_hit[0] = (wake_src[0] | timer_exp) & wake_en_reg[0];
   end

   // GPIO interrupts: edge or level, only when CPU runs
   always_comb begin
      for (int i = 0; i < `PSWC_NGPIO; i++) begin
         if (gpio_cfg_reg[i+4]) begin
            gpio_hit[i] = gpio_cfg_reg[i] & gpio_in[i] & ~gpio_prev_reg[i];
         end else begin
            gpio_hit[i] = gpio_cfg_reg[i] & gpio_in[i];
         end
      end
      if (state_reg != PSWC_ST_AWAKE) begin
         gpio_hit = 4'h0;
      end
   end

   assign wake_any = (|src_hit) | force_evt_reg
                     | ((|gpio_pend_reg) & (state_reg == PSWC_ST_DOZE));

   // Causes raised this cycle
   always_comb begin
      cause_set = 10'h000;
      cause_set[`PSWC_CAUSE_FORCE] = force_evt_reg;
      cause_set[`PSWC_CAUSE_TIMER] = timer_exp;
      cause_set[`PSWC_CAUSE_SRC]   = |(src_hit & 5'h1E);
      cause_set[`PSWC_CAUSE_GPIO]  = |gpio_hit;
   end

   // Power state sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= PSWC_ST_RESET;
         seq_cnt_reg <= 8'h00;
      end else if (rst_src) begin
         state_reg   <= PSWC_ST_RESET;
         seq_cnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            PSWC_ST_RESET: begin
               seq_cnt_reg <= seq_cnt_reg + 8'h01;
               if (seq_cnt_reg == `PSWC_RST_HOLD) begin
                  state_reg <= PSWC_ST_RESTORE;
               end
            end
            PSWC_ST_RESTORE: begin
               if (restore_done) begin
                  state_reg <= PSWC_ST_POWERUP;
                  seq_cnt_reg <= 8'h00;
               end
            end
            PSWC_ST_POWERUP: begin
               seq_cnt_reg <= seq_cnt_reg + 8'h01;
               if (seq_cnt_reg == `PSWC_PWR_SETTLE) begin
                  state_reg <= PSWC_ST_AWAKE;
               end
            end
            PSWC_ST_AWAKE: begin
               if (wr_en && hit(apb_req.paddr, `PSWC_CTRL_OFF) &&
                   !hold_awake) begin
                  if (apb_req.pwdata[`PSWC_CTRL_SLEEP]) begin
                     state_reg <= PSWC_ST_ASLEEP;
                  end else if (apb_req.pwdata[`PSWC_CTRL_DOZE]) begin
                     state_reg <= PSWC_ST_DOZE;
                  end
               end
            end
            PSWC_ST_DOZE: begin
               if (wake_any || hold_awake) begin
                  state_reg <= PSWC_ST_AWAKE;
               end
            end
            PSWC_ST_ASLEEP: begin
               if (wake_any || hold_awake) begin
                  state_reg   <= PSWC_ST_POWERUP;
                  seq_cnt_reg <= 8'h00;
               end
            end
            default: state_reg <= PSWC_ST_RESET;
         endcase
      end
   end

   // Power, clock and core reset outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr <= '0;
      end else begin
         pwr.core_pwr_en <= (state_reg == PSWC_ST_POWERUP) ||
                            (state_reg == PSWC_ST_AWAKE) ||
                            (state_reg == PSWC_ST_DOZE);
         pwr.io_pwr_en   <= (state_reg == PSWC_ST_AWAKE) ||
                            (state_reg == PSWC_ST_DOZE);
         pwr.osc_en      <= (state_reg == PSWC_ST_POWERUP) ||
                            (state_reg == PSWC_ST_AWAKE) ||
                            (state_reg == PSWC_ST_DOZE);
         pwr.cpu_clk_en  <= (state_reg == PSWC_ST_AWAKE);
         pwr.core_rst_n  <= (state_reg == PSWC_ST_AWAKE) ||
                            (state_reg == PSWC_ST_DOZE);
      end
   end

   // Always-on memory restore request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restore_req_reg <= 1'b0;
      end else begin
         restore_req_reg <= (state_reg == PSWC_ST_RESTORE) &
                            ~restore_done;
      end
   end
   assign restore.req  = restore_req_reg;
   assign restore.done = 1'b0;

   // Hold-awake qualification counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_cnt_reg  <= 32'h0;
         force_evt_reg  <= 1'b0;
         force_seen_reg <= 1'b0;
      end else begin
         force_evt_reg <= 1'b0;
         if (!hold_awake) begin
            force_cnt_reg  <= 32'h0;
            force_seen_reg <= 1'b0;
         end else if (force_cnt_reg < FORCE_CYC - 1) begin
            force_cnt_reg <= force_cnt_reg + 32'h1;
         end else if (!force_seen_reg) begin
            force_evt_reg  <= 1'b1;
            force_seen_reg <= 1'b1;
         end
      end
   end

   // Always-on timer, counts in every state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg     <= 32'h0;
         timer_run_reg <= 1'b0;
      end else if (wr_en && hit(apb_req.paddr, `PSWC_TIMER_OFF)) begin
         timer_reg     <= apb_req.pwdata;
         timer_run_reg <= (apb_req.pwdata != 32'h0);
      end else if (timer_run_reg) begin
         timer_reg <= timer_reg - 32'h1;
         if (timer_reg == 32'h1) begin
            timer_run_reg <= 1'b0;
         end
      end
   end

   // Configuration registers, held through doze and sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_en_reg  <= `PSWC_WAKE_EN_RST;
         gpio_cfg_reg <= 8'h00;
         crit_reg     <= `PSWC_CRIT_RST;
         crit_chk_reg <= ~`PSWC_CRIT_RST;
      end else if (wr_en) begin
         if (hit(apb_req.paddr, `PSWC_WAKE_EN_OFF)) begin
            wake_en_reg <= apb_req.pwdata[4:0];
         end
         if (hit(apb_req.paddr, `PSWC_GPIO_CFG_OFF)) begin
            gpio_cfg_reg <= apb_req.pwdata[7:0];
         end
         if (hit(apb_req.paddr, `PSWC_CRIT_OFF)) begin
            crit_reg     <= apb_req.pwdata[15:0];
            crit_chk_reg <= ~apb_req.pwdata[15:0];
         end
      end
   end

   // Software reset request, self clearing one cycle after it is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swrst_reg <= 1'b0;
      end else if (swrst_reg) begin
         swrst_reg <= 1'b0;
      end else if (wr_en && hit(apb_req.paddr, `PSWC_CTRL_OFF)) begin
         swrst_reg <= apb_req.pwdata[`PSWC_CTRL_SWRST];
      end
   end

   // GPIO edge memory and pending interrupts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_prev_reg <= 4'h0;
         gpio_pend_reg <= 4'h0;
      end else begin
         gpio_prev_reg <= gpio_in;
         if (state_reg != PSWC_ST_AWAKE && state_reg != PSWC_ST_DOZE) begin
            gpio_pend_reg <= 4'h0;
         end else begin
            gpio_pend_reg <= gpio_hit | (gpio_cfg_reg[3:0] & gpio_pend_reg);
         end
      end
   end

   // Brownout memory survives the reset it causes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brown_seen_reg <= 1'b0;
      end else if (brownout) begin
         brown_seen_reg <= 1'b1;
      end else if (state_reg == PSWC_ST_AWAKE) begin
         brown_seen_reg <= 1'b0;
      end
   end

   // Cause register: set wins over a CPU clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_reg <= 10'h001;
      end else begin
         if (wr_en && hit(apb_req.paddr, `PSWC_CAUSE_OFF)) begin
            cause_reg <= (cause_reg & ~apb_req.pwdata[9:0]) | cause_set;
         end else begin
            cause_reg <= cause_reg | cause_set;
         end
         if (~por_n) cause_reg[`PSWC_CAUSE_POR] <= 1'b1;
         if (~ext_reset_n) cause_reg[`PSWC_CAUSE_EXTRST] <= 1'b1;
         if (swrst_reg) cause_reg[`PSWC_CAUSE_SWRST] <= 1'b1;
         if (crit_fail) cause_reg[`PSWC_CAUSE_CRIT] <= 1'b1;
         if (brown_seen_reg && state_reg == PSWC_ST_AWAKE) begin
            cause_reg[`PSWC_CAUSE_BROWN] <= 1'b1;
         end
      end
   end

   // Merged interrupt to the CPU
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (|src_hit) | (|gpio_pend_reg) | force_evt_reg
                    | (|cause_reg[`PSWC_CAUSE_GPIO:`PSWC_CAUSE_FORCE]);
      end
   end
   assign cpu_irq = irq_reg;

   // APB answer: one wait state on every access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= apb_req.psel & apb_req.penable & ~pready_reg;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
         if (rd_en && !pready_reg) begin
            case (apb_req.paddr)
               `PSWC_CTRL_OFF:     prdata_reg <= {31'h0, hold_awake};
               `PSWC_STATUS_OFF:   prdata_reg <= {24'h0, gpio_pend_reg,
                                                  1'b0, state_reg};
               `PSWC_WAKE_EN_OFF:  prdata_reg <= {27'h0, wake_en_reg};
               `PSWC_CAUSE_OFF:    prdata_reg <= {22'h0, cause_reg};
               `PSWC_TIMER_OFF:    prdata_reg <= timer_reg;
               `PSWC_GPIO_CFG_OFF: prdata_reg <= {24'h0, gpio_cfg_reg};
               `PSWC_CRIT_OFF:     prdata_reg <= {16'h0, crit_reg};
               `PSWC_CRIT_CHK_OFF: prdata_reg <= {16'h0, crit_chk_reg};
               default:            pslverr_reg <= 1'b1;
            endcase
         end else if (apb_req.psel && apb_req.penable && !pready_reg) begin
            case (apb_req.paddr)
               `PSWC_CTRL_OFF, `PSWC_WAKE_EN_OFF, `PSWC_CAUSE_OFF,
               `PSWC_TIMER_OFF, `PSWC_GPIO_CFG_OFF,
               `PSWC_CRIT_OFF: pslverr_reg <= 1'b0;
               default:        pslverr_reg <= 1'b1;
            endcase
         end
      end
   end
   assign apb_rsp.pready  = pready_reg;
   assign apb_rsp.prdata  = prdata_reg;
   assign apb_rsp.pslverr = pslverr_reg;

endmodule : pswc_power_manager

// *** tb/pswc_power_manager_monitor.sv ***
`timescale 1ns/1ps
module pswc_power_manager_monitor (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // Register bus
   input wire pswc_pkg::pswc_apb_req_t apb_req,
   input wire pswc_pkg::pswc_apb_rsp_t apb_rsp,
   // Reset, wake and interrupt sources
   input wire logic                    por_n,
   input wire logic                    ext_reset_n,
   input wire logic                    brownout,
   input wire logic                    hold_awake,
   input wire logic [4:0]              wake_src,
   input wire logic [3:0]              gpio_in,
   // Restore handshake and power controls
   input wire logic                    restore_done,
   input wire pswc_pkg::pswc_restore_t restore,
   input wire pswc_pkg::pswc_pwr_t     pwr,
   input wire logic                    cpu_irq
);
   import pswc_pkg::*;

   logic quiet;

   // No power-on, external or brownout reset active
   assign quiet = por_n && ext_reset_n && !brownout;

   default clocking mon_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Bus access, doze and hold-awake steps
   sequence s_access;
      apb_req.psel && $rose(apb_req.penable);
   endsequence
   sequence s_one_wait;
      !apb_rsp.pready ##1 apb_rsp.pready;
   endsequence
   sequence s_dozing;
      pwr.core_pwr_en && pwr.core_rst_n && !pwr.cpu_clk_en && quiet;
   endsequence
   sequence s_held;
      hold_awake && pwr.cpu_clk_en && quiet ##1 hold_awake && quiet;
   endsequence

   // Power domain and bus relations
   AST_ASLEEP_CORE_OFF: assert property (
      !pwr.core_pwr_en |-> !pwr.io_pwr_en && !pwr.cpu_clk_en)
      else $error("core off with io or cpu clock on");
   AST_AWAKE_DOMAINS: assert property (
      pwr.cpu_clk_en |-> pwr.io_pwr_en && pwr.osc_en && pwr.core_rst_n)
      else $error("cpu clocked without io, oscillator or release");
   AST_ONE_WAIT: assert property (
      s_access |-> s_one_wait)
      else $error("bus answer not after one wait state");
   AST_IDLE_ZERO: assert property (
      apb_rsp.pready |=> !apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("bus answer held past one cycle");
   AST_BROWNOUT_HOLD: assert property (
      brownout [*2] |=> !pwr.core_rst_n && !pwr.cpu_clk_en)
      else $error("core released during brownout");
   AST_EXT_RESET: assert property (
      !ext_reset_n [*2] |=> !pwr.core_rst_n)
      else $error("core released during external reset");
   AST_DOZE_WAKE: assert property (
      s_dozing ##0 (|wake_src) |-> ##[1:9] pwr.cpu_clk_en)
      else $error("cpu clock not back within 45 ns");
   AST_HOLD_REFUSE: assert property (
      s_held |-> pwr.cpu_clk_en)
      else $error("cpu clock stopped while held awake");
   AST_RESTORE_CORE_OFF: assert property (
      restore.req |-> !pwr.core_pwr_en && !pwr.core_rst_n)
      else $error("restore requested with core powered");
   AST_RESTORE_END: assert property (
      restore.req && restore_done |=> !restore.req)
      else $error("restore request held after done");
endmodule : pswc_power_manager_monitor

bind pswc_power_manager pswc_power_manager_monitor
   pswc_power_manager_monitor_i (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .por_n(por_n), .ext_reset_n(ext_reset_n), .brownout(brownout),
   .hold_awake(hold_awake), .wake_src(wake_src), .gpio_in(gpio_in),
   .restore_done(restore_done), .restore(restore), .pwr(pwr),
   .cpu_irq(cpu_irq));

// *** tb/pswc_flash_model.sv ***
`timescale 1ns/1ps
module pswc_flash_model (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Restore handshake and answer delay
   input  wire pswc_pkg::pswc_restore_t restore,
   input  wire logic [7:0]              delay,
   output logic                         restore_done
);
   import pswc_pkg::*;

   logic [7:0] cnt_reg;

   // Copy the backup, then hold done until the request drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg      <= 8'h00;
         restore_done <= 1'h0;
      end else if (!restore.req) begin
         cnt_reg      <= 8'h00;
         restore_done <= 1'h0;
      end else if (cnt_reg >= delay) begin
         restore_done <= 1'h1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : pswc_flash_model

// *** tb/test_power_state_wake_controller.sv ***
`timescale 1ns/1ps
`include "pswc_defines.svh"
module test_power_state_wake_controller;
   import pswc_pkg::*;

   logic          pclk;
   logic          presetn;
   pswc_apb_req_t req;
   pswc_apb_rsp_t rsp;
   logic          por_n;
   logic          ext_reset_n;
   logic          brownout;
   logic          hold_awake;
   logic [4:0]    wake_src;
   logic [3:0]    gpio_in;
   logic          restore_done;
   logic [7:0]    delay;
   pswc_restore_t restore;
   pswc_pwr_t     pwr;
   logic          cpu_irq;
   logic [31:0]   rdata;
   logic          err;
   int            mismatches;
   int            checks_done;

   // Block and flash partner
   pswc_power_manager pswc_power_manager_i (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .por_n(por_n), .ext_reset_n(ext_reset_n), .brownout(brownout),
      .hold_awake(hold_awake), .wake_src(wake_src), .gpio_in(gpio_in),
      .restore_done(restore_done), .restore(restore), .pwr(pwr),
      .cpu_irq(cpu_irq));
   pswc_flash_model pswc_flash_model_i (
      .pclk(pclk), .presetn(presetn), .restore(restore), .delay(delay),
      .restore_done(restore_done));

   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bus transfer: setup, then access held until ready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      req.psel    <= 1'h1;
      req.penable <= 1'h0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge pclk);
      req.penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'h1 && n < 20);
      if (rsp.pready !== 1'h1) begin
         mismatches++;
         stop_test();
      end
      rdata = rsp.prdata;
      err   = rsp.pslverr;
      req.psel    <= 1'h0;
      req.penable <= 1'h0;
   endtask : apb

   // Read and compare a register
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(nm, e, rdata);
   endtask : rdc

   // Idle cycles
   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycles

   // Wait for a running, released CPU under a bound
   task automatic wait_awake;
      int n;
      n = 0;
      while (pwr.core_rst_n !== 1'h1 || pwr.cpu_clk_en !== 1'h1) begin
         @(posedge pclk);
         n++;
         if (n == 3000) begin
            mismatches++;
            stop_test();
         end
      end
      chk("awake pwr", 32'h1F, {27'h0, pwr});
   endtask : wait_awake

   // Check one cause bit, then clear all causes
   task automatic cause_is(input int b);
      apb(1'h0, `PSWC_CAUSE_OFF, 32'h0);
      chk("cause bit", 32'h1, {31'h0, rdata[b]});
      apb(1'h1, `PSWC_CAUSE_OFF, 32'h1FF);
   endtask : cause_is

   // Boot, defaults, cause clearing and register protection
   task automatic s_boot;
      cycles(22);
      chk("restore req", 32'h1, {31'h0, restore.req});
      chk("core held", 32'h0, {31'h0, pwr.core_rst_n});
      wait_awake();
      rdc("cause rst", `PSWC_CAUSE_OFF, 32'h1);
      apb(1'h1, `PSWC_CAUSE_OFF, 32'h1);
      rdc("cause clr", `PSWC_CAUSE_OFF, 32'h0);
      rdc("wake en", `PSWC_WAKE_EN_OFF, 32'h1F);
      delay <= 8'h00;
      apb(1'h1, `PSWC_CRIT_OFF, 32'h1234);
      rdc("crit copy", `PSWC_CRIT_CHK_OFF, 32'hEDCB);
      apb(1'h1, `PSWC_CRIT_CHK_OFF, 32'h0);
      chk("copy ro", 32'h1, {31'h0, err});
      apb(1'h0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      chk("no crit rst", 32'h1, {31'h0, pwr.core_rst_n});
   endtask : s_boot

   // Doze, retention and fast wake
   task automatic s_doze;
      int n;
      apb(1'h1, `PSWC_CTRL_OFF, 32'h2);
      cycles(3);
      chk("doze", 32'h2, {30'h0, pwr.core_pwr_en, pwr.cpu_clk_en});
      rdc("doze state", `PSWC_STATUS_OFF, 32'h4);
      rdc("doze keep", `PSWC_CRIT_OFF, 32'h1234);
      wake_src <= 5'h02;
      n = 0;
      while (pwr.cpu_clk_en !== 1'h1 && n < 9) begin
         @(posedge pclk);
         n++;
      end
      chk("doze wake", 32'h1, {31'h0, pwr.cpu_clk_en});
      wake_src <= 5'h00;
      cause_is(7);
   endtask : s_doze

   // Sleep with timer wake
   task automatic s_sleep;
      apb(1'h1, `PSWC_TIMER_OFF, 32'hC8);
      apb(1'h1, `PSWC_CTRL_OFF, 32'h1);
      cycles(4);
      chk("asleep pwr", 32'h0, {27'h0, pwr});
      wait_awake();
      cause_is(6);
   endtask : s_sleep

   // Power-on, external and brownout resets, then software reset
   task automatic s_resets;
      int bits[3] = '{0, 1, 3};
      for (int k = 0; k < 3; k++) begin
         por_n       <= (k != 0);
         ext_reset_n <= (k != 1);
         brownout    <= (k == 2);
         cycles(10);
         chk("in reset", 32'h0, {31'h0, pwr.core_rst_n});
         por_n       <= 1'h1;
         ext_reset_n <= 1'h1;
         brownout    <= 1'h0;
         wait_awake();
         cause_is(bits[k]);
      end
      apb(1'h1, `PSWC_CTRL_OFF, 32'h4);
      cycles(4);
      wait_awake();
      cause_is(2);
   endtask : s_resets

   // Hold-awake refusals and forced wake event
   task automatic s_hold;
      hold_awake <= 1'h1;
      apb(1'h1, `PSWC_CTRL_OFF, 32'h2);
      cycles(3);
      chk("doze refused", 32'h1, {31'h0, pwr.cpu_clk_en});
      apb(1'h1, `PSWC_CTRL_OFF, 32'h1);
      cycles(3);
      chk("sleep refused", 32'h1, {31'h0, pwr.io_pwr_en});
      apb(1'h0, `PSWC_CTRL_OFF, 32'h0);
      chk("hold bit", 32'h1, {31'h0, rdata[0]});
      cycles(49010);
      hold_awake <= 1'h0;
      cause_is(5);
   endtask : s_hold

   // Level interrupt on the first pin, edge interrupt on the second
   task automatic s_gpio;
      int n;
      apb(1'h1, `PSWC_GPIO_CFG_OFF, 32'h1);
      gpio_in <= 4'h1;
      n = 0;
      while (cpu_irq !== 1'h1 && n < 8) begin
         @(posedge pclk);
         n++;
      end
      chk("gpio irq", 32'h1, {31'h0, cpu_irq});
      apb(1'h0, `PSWC_STATUS_OFF, 32'h0);
      chk("gpio pend", 32'h13, {24'h0, rdata[7:4], 1'h0, rdata[2:0]});
      gpio_in <= 4'h2;
      apb(1'h1, `PSWC_GPIO_CFG_OFF, 32'h22);
      rdc("edge held high", `PSWC_STATUS_OFF, 32'h3);
      gpio_in <= 4'h0;
      cycles(1);
      gpio_in <= 4'h2;
      rdc("edge pend", `PSWC_STATUS_OFF, 32'h23);
      gpio_in <= 4'h0;
   endtask : s_gpio

   // Clock
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end

   // Main sequence
   initial begin
      req         = '0;
      presetn     = 1'h0;
      por_n       = 1'h1;
      ext_reset_n = 1'h1;
      brownout    = 1'h0;
      hold_awake  = 1'h0;
      wake_src    = 5'h00;
      gpio_in     = 4'h0;
      delay       = 8'h0A;
      mismatches  = 0;
      checks_done = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      s_boot();
      s_doze();
      s_sleep();
      s_resets();
      s_hold();
      s_gpio();
      stop_test();
   end
endmodule : test_power_state_wake_controller
